// [design/ubw_break_wake.sv]
`timescale 1ns/1ps
`default_nettype none

module ubw_break_wake (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        sleep,
  input  wire logic        syncMode,
  input  wire logic [15:0] baudDiv,
  input  wire logic        txEnable,
  input  wire logic        txWrite,
  input  wire logic [7:0]  txData,
  input  wire logic        sendBreakSet,
  input  wire logic        wakeEnableSet,
  input  wire logic        rxLine,
  input  wire logic        rxRead,
  input  wire logic        overrunClear,
  output logic             txLine,
  output logic             shiftEmptyFlag,
  output logic             txBufEmptyFlag,
  output logic             sendBreakRequest,
  output logic             wakeOnEdgeEnable,
  output logic             receiveIdleFlag,
  output logic             receiveFlag,
  output logic [7:0]       rxData,
  output logic             framingErrorFlag,
  output logic             wakeEventFlag,
  output logic             overrunFlag
);

  ubw_pkg::ubw_state_t s;         // Registered state
  ubw_pkg::ubw_state_t n;         // Next state
  ubw_pkg::ubw_word_t  headWord;  // Entry at the buffer head
  logic                bufReady;  // Buffer can take an entry
  logic                txTick;    // End of a transmit bit time
  logic                rxTick;    // Receive sample point
  logic                rxFall;    // Receive line went low
  logic                rxRise;    // Receive line went high
  logic                wakeOn;    // Wake watch is active

  // Bit-time dividers stop while asleep
  assign txTick = !sleep && (s.txCnt == '0);
  assign rxTick = !sleep && (s.rxCnt == '0);
  // Edge detection runs without the divider, so it works in sleep
  assign rxFall = s.rxPrev && !rxLine;
  assign rxRise = !s.rxPrev && rxLine;
  assign wakeOn = s.wakeEn && !syncMode;

  // Next-state logic for both directions
  always_comb begin
    n = s;
    n.pushValid = 1'h0;
    n.rxPrev = rxLine;

    // Holding register takes a write only when empty and enabled
    if (txWrite && txEnable && !s.holdValid) begin
      n.holdValid = 1'h1;
      n.holdData = txData;
    end
    // Transmit bit-time countdown
    if (!sleep && (s.txCnt != '0)) begin
      n.txCnt = s.txCnt - ubw_pkg::CNT_STEP;
    end

    // Transmit sequencer
    case (s.txState)
      ubw_pkg::TX_IDLE: begin
        // Load the shifter; a Break ignores the written value
        if (s.holdValid && txEnable && !sleep) begin
          n.txBreak = s.sendBreak;
          n.txShift = s.sendBreak ? ubw_pkg::BREAK_DATA : s.holdData;
          n.txBitN = s.sendBreak ? ubw_pkg::BREAK_ZEROS : ubw_pkg::DATA_BITS;
          n.holdValid = 1'h0;
          n.txLine = 1'h0;
          n.txCnt = baudDiv - ubw_pkg::CNT_STEP;
          n.txState = ubw_pkg::TX_START;
        end
      end
      ubw_pkg::TX_START: begin
        // Start bit done, first data bit out
        if (txTick) begin
          n.txLine = s.txShift[0];
          n.txShift = s.txShift >> 1;
          n.txBitN = s.txBitN - ubw_pkg::BIT_STEP;
          n.txCnt = baudDiv - ubw_pkg::CNT_STEP;
          n.txState = ubw_pkg::TX_BITS;
        end
      end
      ubw_pkg::TX_BITS: begin
        // Remaining data bits, then the stop bit
        if (txTick) begin
          n.txCnt = baudDiv - ubw_pkg::CNT_STEP;
          if (s.txBitN == '0) begin
            n.txLine = 1'h1;
            n.txState = ubw_pkg::TX_STOP;
          end else begin
            n.txLine = s.txShift[0];
            n.txShift = s.txShift >> 1;
            n.txBitN = s.txBitN - ubw_pkg::BIT_STEP;
          end
        end
      end
      default: begin
        // Stop bit sent; a finished Break drops its request
        if (txTick) begin
          if (s.txBreak) begin
            n.sendBreak = 1'h0;
          end
          n.txBreak = 1'h0;
          n.txState = ubw_pkg::TX_IDLE;
        end
      end
    endcase
    // Software set wins over the hardware clear
    if (sendBreakSet) begin
      n.sendBreak = 1'h1;
    end
    n.shiftEmpty = (n.txState == ubw_pkg::TX_IDLE);
    n.txBufEmpty = txEnable && !n.holdValid;

    // Receive bit-time countdown
    if (!sleep && (s.rxCnt != '0)) begin
      n.rxCnt = s.rxCnt - ubw_pkg::CNT_STEP;
    end

    if (wakeOn) begin
      // Normal reception suppressed while watching for a wake
      n.rxState = ubw_pkg::RX_IDLE;
      if (rxFall) begin
        // Dummy entry raises the receive flag with the edge
        n.pushValid = 1'h1;
        n.pushWord = '{data: ubw_pkg::BREAK_DATA, frameErr: 1'h0, wake: 1'h1};
      end
      // First rise ends the wake; a non-zero character's tail
      // is then taken as a fresh character fragment
      if (rxRise) begin
        n.wakeEn = 1'h0;
      end
    end else begin
      // Receive sequencer; next byte after a wake flags again
      case (s.rxState)
        ubw_pkg::RX_IDLE: begin
          // No new character is started while asleep
          if (rxFall && !sleep) begin
            n.rxCnt = baudDiv >> 1;
            n.rxState = ubw_pkg::RX_START;
          end
        end
        ubw_pkg::RX_START: begin
          // Mid start bit: confirm it is still low
          if (rxTick) begin
            n.rxCnt = baudDiv - ubw_pkg::CNT_STEP;
            n.rxBitN = ubw_pkg::DATA_BITS;
            n.rxState = rxLine ? ubw_pkg::RX_IDLE : ubw_pkg::RX_BITS;
          end
        end
        ubw_pkg::RX_BITS: begin
          // Shift in least significant bit first
          if (rxTick) begin
            n.rxShift = {rxLine, s.rxShift[7:1]};
            n.rxBitN = s.rxBitN - ubw_pkg::BIT_STEP;
            n.rxCnt = baudDiv - ubw_pkg::CNT_STEP;
            if (s.rxBitN == ubw_pkg::BIT_STEP) begin
              n.rxState = ubw_pkg::RX_STOP;
            end
          end
        end
        default: begin
          // Low stop bit marks a framing error; a Break reads 00h
          if (rxTick) begin
            n.pushValid = 1'h1;
            n.pushWord = '{data: s.rxShift, frameErr: !rxLine, wake: 1'h0};
            n.rxState = ubw_pkg::RX_IDLE;
          end
        end
      endcase
    end
    // Software enable refused in synchronous mode; set wins
    if (wakeEnableSet && !syncMode) begin
      n.wakeEn = 1'h1;
    end
    // Overrun when the buffer is full; set wins over clear
    if (overrunClear) begin
      n.overrun = 1'h0;
    end
    if (s.pushValid && !bufReady) begin
      n.overrun = 1'h1;
    end
    n.rxIdle = (n.rxState == ubw_pkg::RX_IDLE);
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= ubw_pkg::UBW_RESET;
    end else begin
      s <= n;
    end
  end

  // Received entries wait here until software reads them
  ubw_skid #(.WIDTH(ubw_pkg::WORD_W)) uBuf (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (s.pushValid),
    .inData   (s.pushWord),
    .inReady  (bufReady),
    .outValid (receiveFlag),
    .outData  (headWord),
    .outReady (rxRead)
  );

  // Outputs straight from state flops
  assign txLine           = s.txLine;
  assign shiftEmptyFlag   = s.shiftEmpty;
  assign txBufEmptyFlag   = s.txBufEmpty;
  assign sendBreakRequest = s.sendBreak;
  assign wakeOnEdgeEnable = s.wakeEn;
  assign receiveIdleFlag  = s.rxIdle;
  assign rxData           = headWord.data;
  assign framingErrorFlag = headWord.frameErr;
  assign wakeEventFlag    = headWord.wake;
  assign overrunFlag      = s.overrun;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_sleep_freeze;
    sleep |=> $stable(s.txCnt) && $stable(s.rxCnt) && $stable(s.rxState);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("counter ran in sleep");

  property p_sync_refuse;
    syncMode && !s.wakeEn |=> !s.wakeEn;
  endproperty
  a_sync_refuse: assert property (p_sync_refuse) else $error("wake set in sync mode");

  property p_wake_idle;
    s.wakeEn && !syncMode |=> s.rxState == ubw_pkg::RX_IDLE;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("receiver busy in wake");

  property p_wake_fall;
    s.wakeEn && !syncMode && rxFall |=> s.pushValid && s.pushWord.wake ##1 receiveFlag;
  endproperty
  a_wake_fall: assert property (p_wake_fall) else $error("wake edge gave no flag");

  property p_read_clear;
    receiveFlag && rxRead && bufReady && !s.pushValid |=> !receiveFlag;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read left flag set");

  property p_wake_end;
    s.wakeEn && !syncMode && rxRise && !wakeEnableSet |=> !s.wakeEn;
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("wake enable not cleared");

  property p_break_load;
    s.txState == ubw_pkg::TX_START && s.txBreak |->
      s.txShift == ubw_pkg::BREAK_DATA && s.txBitN == ubw_pkg::BREAK_ZEROS && !txLine;
  endproperty
  a_break_load: assert property (p_break_load) else $error("break load wrong");

  property p_break_clear;
    s.txState == ubw_pkg::TX_STOP && s.txBreak && txTick && !sendBreakSet
      |=> !sendBreakRequest && shiftEmptyFlag;
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("break request kept");

  property p_shift_empty;
    // A low line always means a character or Break is on its way out
    (shiftEmptyFlag == (s.txState == ubw_pkg::TX_IDLE)) && (txLine || !shiftEmptyFlag);
  endproperty
  a_shift_empty: assert property (p_shift_empty) else $error("shift empty wrong");

  property p_buf_empty;
    $past(txEnable) && !s.holdValid |-> txBufEmptyFlag;
  endproperty
  a_buf_empty: assert property (p_buf_empty) else $error("buffer empty flag low");

  property p_rx_break;
    !wakeOn && s.rxState == ubw_pkg::RX_STOP && rxTick && !rxLine && s.rxShift == '0
      |=> s.pushValid && s.pushWord.frameErr && s.pushWord.data == ubw_pkg::BREAK_DATA;
  endproperty
  a_rx_break: assert property (p_rx_break) else $error("break not reported");

  c_wake: cover property (s.pushValid && s.pushWord.wake);
  c_tx_break: cover property (s.txBreak && s.txState == ubw_pkg::TX_STOP);
  c_rx_break: cover property (receiveFlag && framingErrorFlag);
  c_overrun: cover property (s.pushValid && !bufReady);

endmodule

`default_nettype wire

// [design/ubw_pkg.sv]
package ubw_pkg;

  // Width of the bit-time divisor
  localparam int unsigned DIV_W       = 16;
  // Data bits in an ordinary character
  localparam logic [3:0]  DATA_BITS   = 4'h8;
  // Zero bits following the start bit of a Break
  localparam logic [3:0]  BREAK_ZEROS = 4'hc;
  // Value shifted out during a Break
  localparam logic [7:0]  BREAK_DATA  = 8'h00;
  // Step for the bit-time counters
  localparam logic [15:0] CNT_STEP    = 16'h0001;
  // Step for the bit counters
  localparam logic [3:0]  BIT_STEP    = 4'h1;

  // Transmit sequencer states
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} ubw_tx_t;
  // Receive sequencer states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} ubw_rx_t;

  // One received entry handed to software
  typedef struct packed {
    logic [7:0] data;  // Received byte
    logic       frameErr;  // Stop bit was low
    logic       wake;  // Entry made by a wake event
  } ubw_word_t;

  // Width of one buffered entry
  localparam int unsigned WORD_W = $bits(ubw_word_t);

  // Complete state of the break and wake unit
  typedef struct packed {
    ubw_tx_t    txState;
    logic [15:0] txCnt;
    logic [3:0] txBitN;
    logic [7:0] txShift;
    logic       txBreak;
    logic       holdValid;
    logic [7:0] holdData;
    logic       sendBreak;
    logic       txLine;
    logic       shiftEmpty;
    logic       txBufEmpty;
    ubw_rx_t    rxState;
    logic [15:0] rxCnt;
    logic [3:0] rxBitN;
    logic [7:0] rxShift;
    logic       rxPrev;
    logic       wakeEn;
    logic       pushValid;
    ubw_word_t  pushWord;
    logic       overrun;
    logic       rxIdle;
  } ubw_state_t;

  // Reset value: line idles at mark, both sides idle
  localparam ubw_state_t UBW_RESET = '{txState: TX_IDLE, rxState: RX_IDLE,
    txLine: 1'h1, shiftEmpty: 1'h1, rxPrev: 1'h1, rxIdle: 1'h1, default: '0};

endpackage

// [design/ubw_skid.sv]
`timescale 1ns/1ps
`default_nettype none

// Two-entry buffer; head entry drives the outputs straight from flops
module ubw_skid #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);

  // Head and second entry
  typedef struct packed {
    logic             v0;
    logic [WIDTH-1:0] d0;
    logic             v1;
    logic [WIDTH-1:0] d1;
  } ubw_skid_t;

  ubw_skid_t s;  // Registered state
  ubw_skid_t n;  // Next state

  // Pop first, then push into the first free entry
  always_comb begin
    n = s;
    if (outReady && s.v0) begin
      if (s.v1) begin
        n.d0 = s.d1;
        n.v1 = 1'h0;
      end else begin
        n.v0 = 1'h0;
      end
    end
    if (inValid && !s.v1) begin
      if (!n.v0) begin
        n.v0 = 1'h1;
        n.d0 = inData;
      end else begin
        n.v1 = 1'h1;
        n.d1 = inData;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Full only when the second entry is taken
  assign inReady  = !s.v1;
  assign outValid = s.v0;
  assign outData  = s.d0;

endmodule

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the break and wake unit
module testbench;
  // One ordinary case: character value and stop level
  typedef struct packed {
    logic [7:0] data;
    logic       stop;
  } ubw_row_t;

  logic        mclk, rst, sleep, syncMode, txEnable, txWrite, sendBreakSet;
  logic        wakeEnableSet, rxLine, rxRead, overrunClear;
  logic [7:0]  txData, rxData;
  logic [15:0] baudDiv;
  logic        txLine, shiftEmptyFlag, txBufEmptyFlag, sendBreakRequest;
  logic        wakeOnEdgeEnable, receiveIdleFlag, receiveFlag;
  logic        framingErrorFlag, wakeEventFlag, overrunFlag;
  int          fails = 0;
  int          n_checks = 0;
  // Last one is a received Break: zero data, low stop
  ubw_row_t    rows [4] = '{'{8'h00, 1'h1}, '{8'ha5, 1'h1}, '{8'hff, 1'h1}, '{8'h00, 1'h0}};

  ubw_break_wake dut (.mclk, .rst, .sleep, .syncMode, .baudDiv, .txEnable, .txWrite,
    .txData, .sendBreakSet, .wakeEnableSet, .rxLine, .rxRead, .overrunClear, .txLine,
    .shiftEmptyFlag, .txBufEmptyFlag, .sendBreakRequest, .wakeOnEdgeEnable,
    .receiveIdleFlag, .receiveFlag, .rxData, .framingErrorFlag, .wakeEventFlag,
    .overrunFlag);

  ubw_remote_node #(.BIT_T(4)) node (.mclk, .txLine, .rxLine);

  // Counts, verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Word compare
  task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Flag compare
  task automatic chkBit(input logic got, input logic exp);
    chkWord({15'h0000, got}, {15'h0000, exp});
  endtask

  // A used-up wait counts as a mismatch and ends the run
  task automatic tmo(input int t);
    if (t >= 300) begin
      fails++;
      $display("wait limit reached at %0t", $time);
      complete_run;
    end
  endtask

  // One write to the transmit data register
  task automatic pulseWr(input logic [7:0] d);
    @(posedge mclk);
    txWrite <= 1'h1;
    txData  <= d;
    @(posedge mclk);
    txWrite <= 1'h0;
  endtask

  // One read of the receive data register
  task automatic rdRx;
    @(posedge mclk);
    rxRead <= 1'h1;
    @(posedge mclk);
    rxRead <= 1'h0;
    repeat (2) @(negedge mclk);
  endtask

  // Bounded wait for the receive flag
  task automatic waitRx;
    int t;
    t = 0;
    while (receiveFlag !== 1'h1 && t < 300) begin
      @(negedge mclk);
      t++;
    end
    tmo(t);
  endtask

  // Pop whatever is still buffered
  task automatic drain;
    for (int i = 0; i < 4; i++) if (receiveFlag === 1'h1) rdRx;
  endtask

  // Ordinary character from the remote node
  task automatic rxChar(input logic [7:0] d, input logic stop);
    node.sendBits({6'h00, stop, d, 1'h0}, 10);
  endtask

  // Free-running clock
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    logic [15:0] bits;
    logic        ok;
    int          t;
    {rst, sleep, syncMode, txEnable, txWrite, sendBreakSet} = 6'h20;
    {wakeEnableSet, rxRead, overrunClear, txData} = 11'h000;
    baudDiv = 16'h0004;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    // Write with transmitter off is dropped, buffer flag follows enable
    pulseWr(8'h5a);
    repeat (4) @(negedge mclk);
    chkBit(shiftEmptyFlag, 1'h1);
    chkBit(txBufEmptyFlag, 1'h0);
    @(posedge mclk);
    txEnable <= 1'h1;
    repeat (3) @(negedge mclk);
    chkBit(txBufEmptyFlag, 1'h1);
    $display("test enable done");
    // Ordinary cases: transmit the value, then receive it back
    foreach (rows[i]) begin
      fork
        node.recvBits(10, bits, ok);
        pulseWr(rows[i].data);
      join
      chkBit(ok, 1'h1);
      chkWord(bits, {6'h00, 1'h1, rows[i].data, 1'h0});
      // Receiver must report busy while the character arrives
      fork
        rxChar(rows[i].data, rows[i].stop);
        begin
          repeat (8) @(negedge mclk);
          chkBit(receiveIdleFlag, 1'h0);
        end
      join
      waitRx;
      chkWord({8'h00, rxData}, {8'h00, rows[i].data});
      chkBit(framingErrorFlag, ~rows[i].stop);
      chkBit(wakeEventFlag, 1'h0);
      rdRx;
      chkBit(receiveFlag, 1'h0);
    end
    $display("test rows done");
    // Break with a preloaded sync byte
    @(posedge mclk);
    sendBreakSet <= 1'h1;
    @(posedge mclk);
    sendBreakSet <= 1'h0;
    fork
      node.recvBits(14, bits, ok);
      begin
        pulseWr(8'hff);
        // Poll only once the write has reached the flag
        @(negedge mclk);
        t = 0;
        while (txBufEmptyFlag !== 1'h1 && t < 300) begin
          @(negedge mclk);
          t++;
        end
        tmo(t);
        pulseWr(8'h55);
        repeat (3) @(negedge mclk);
        chkBit(txBufEmptyFlag, 1'h0);
      end
    join
    chkBit(ok, 1'h1);
    chkWord(bits, 16'h2000);
    chkBit(shiftEmptyFlag, 1'h0);
    chkBit(sendBreakRequest, 1'h1);
    fork
      node.recvBits(10, bits, ok);
      begin
        t = 0;
        while (sendBreakRequest !== 1'h0 && t < 300) begin
          @(negedge mclk);
          t++;
        end
        tmo(t);
        chkBit(shiftEmptyFlag, 1'h1);
      end
    join
    chkWord(bits, 16'h02aa);
    $display("test break done");
    // Asleep without wake watch: nothing is received
    @(posedge mclk);
    sleep <= 1'h1;
    rxChar(8'h5a, 1'h1);
    repeat (20) @(negedge mclk);
    chkBit(receiveFlag, 1'h0);
    @(posedge mclk);
    sleep <= 1'h0;
    repeat (60) @(negedge mclk);
    drain;
    $display("test sleep done");
    // Wake watch refused in synchronous mode, then a wake during sleep
    chkBit(receiveIdleFlag, 1'h1);
    @(posedge mclk);
    {sleep, syncMode, wakeEnableSet} <= 3'h7;
    @(posedge mclk);
    wakeEnableSet <= 1'h0;
    @(negedge mclk);
    chkBit(wakeOnEdgeEnable, 1'h0);
    @(posedge mclk);
    {syncMode, wakeEnableSet} <= 2'h1;
    @(posedge mclk);
    wakeEnableSet <= 1'h0;
    @(negedge mclk);
    chkBit(wakeOnEdgeEnable, 1'h1);
    fork
      node.sendBits(16'h0000, 13);
      begin
        waitRx;
        chkWord({7'h00, wakeEventFlag, rxData}, 16'h0100);
        chkBit(wakeOnEdgeEnable, 1'h1);
      end
    join
    repeat (3) @(negedge mclk);
    chkBit(wakeOnEdgeEnable, 1'h0);
    @(posedge mclk);
    sleep <= 1'h0;
    rdRx;
    chkBit(receiveFlag, 1'h0);
    // Divisor stays fixed after the Break; rate measurement lies outside the unit
    rxChar(8'h3c, 1'h1);
    waitRx;
    chkWord({8'h00, rxData}, 16'h003c);
    rdRx;
    $display("test wake done");
    // Four characters unread: head kept, loss flagged, then cleared
    for (int i = 1; i < 5; i++) rxChar(8'(i * 8'h11), 1'h1);
    repeat (10) @(negedge mclk);
    chkBit(overrunFlag, 1'h1);
    chkWord({8'h00, rxData}, 16'h0011);
    drain;
    chkBit(receiveFlag, 1'h0);
    @(posedge mclk);
    overrunClear <= 1'h1;
    @(posedge mclk);
    overrunClear <= 1'h0;
    @(negedge mclk);
    chkBit(overrunFlag, 1'h0);
    $display("test overrun done");
    // Reset in mid-run
    @(posedge mclk);
    rst <= 1'h1;
    repeat (2) @(negedge mclk);
    chkWord({8'h00, txLine, shiftEmptyFlag, receiveIdleFlag, txBufEmptyFlag,
      sendBreakRequest, wakeOnEdgeEnable, receiveFlag, overrunFlag}, 16'h00e0);
    $display("test reset done");
    complete_run;
  end
endmodule

`default_nettype wire

// [tb/ubw_remote_node.sv]
`timescale 1ns/1ps
`default_nettype none

// Remote serial node: drives the receive line, listens to the transmit line
module ubw_remote_node #(
  parameter int BIT_T = 4  // Cycles per bit time
) (
  input  wire logic mclk,
  input  wire logic txLine,
  output logic      rxLine
);
  // Line rests at mark between characters
  initial rxLine = 1'h1;

  // Send n bits LSB first, then return to mark; also sends long zero wake runs
  task automatic sendBits(input logic [15:0] bits, input int n);
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      rxLine <= bits[i];
      repeat (BIT_T) @(posedge mclk);
    end
    rxLine <= 1'h1;
  endtask

  // Wait for a start bit, then sample n bits at mid-bit
  task automatic recvBits(input int n, output logic [15:0] bits, output logic ok);
    int t;
    bits = '0;
    t = 0;
    while (txLine !== 1'h0 && t < 300) begin
      @(negedge mclk);
      t++;
    end
    ok = (t < 300);
    repeat (BIT_T / 2) @(negedge mclk);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (BIT_T) @(negedge mclk);
      bits[i] = txLine;
    end
  endtask
endmodule

`default_nettype wire
